// file: hdl/reconfig_pkg.sv
// Shared constants and types for the channel reconfiguration word sequencer
package reconfig_pkg;

    // Mode select codes
    localparam logic [2:0] MODE_ANALOG = 3'h0;
    localparam logic [2:0] MODE_CHANNEL = 3'h1;
    localparam logic [2:0] MODE_RST = 3'h0;

    // Word index
    localparam int IDX_W = 6;
    localparam logic [5:0] IDX_RST = 6'h00;
    localparam logic [5:0] LAST_RST = 6'h3F;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;

    // Control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_LAST_LSB = 8;

    // Status register fields
    localparam int STAT_IDX_LSB = 0;
    localparam int STAT_DONE_BIT = 8;
    localparam int STAT_BUSY_BIT = 9;
    localparam int STAT_OC_BIT = 10;
    localparam int STAT_MERR_BIT = 11;
    localparam int STAT_PEND_BIT = 12;

    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int OC_CYCLES = 16;
    localparam int BUF_DEPTH = 2;

    typedef enum logic [1:0] {
        S_IDLE = 2'b01,
        S_WRITE = 2'b10
    } wr_state_t;

endpackage : reconfig_pkg

// file: hdl/word_buffer.sv
// Small FIFO carrying configuration words toward the channel writer
`timescale 1ns/100ps
module word_buffer #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic full;
    logic empty;
    logic push;
    logic pop;
    logic [CNT_W-1:0] next_count;

    assign push = in_valid_i && !full;
    assign pop = out_ready_i && !empty;
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + CNT_W'(1);
        end else if (pop && !push) begin
            next_count = count - CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            full <= 1'b0;
            empty <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= next_count;
            full <= (next_count == CNT_W'(DEPTH));
            empty <= (next_count == '0);
        end
    end

endmodule : word_buffer

// file: hdl/channel_reconfig_word_sequencer.sv
// Channel reconfiguration word sequencer with offset cancellation timer
`timescale 1ns/100ps
// What this block does
// - Mode code 000 selects analog controls (default), 001 channel mode.
// - Mode field is settable only when several modes are built in.
// - Word index steps by one to the last address, then wraps to zero.
// - Index strobe pulses only after one whole word reached the channel.
// - Controller reset clears all registers except oc_done and aborts any sequence.
// - Controller reset acts only when channel mode is built in.
// - Completion flag rises once the last word is written.
// - Completion flag drops by itself when a new sequence starts.
// - Offset cancellation runs once after power-up, never again after a reset once it has finished.
// - Index, strobe, clear and data work only in channel mode.
// - No mode code selects PLL reconfiguration.
// - Reset held or applied during cancellation delays and restarts it.
// - Busy low first cycle, high from second, low when cancellation ends.
module channel_reconfig_word_sequencer #(
    parameter int WORD_W = 16,
    parameter int MULTI_MODE = 1,
    parameter int HAS_CHANNEL = 1,
    parameter logic [2:0] SINGLE_MODE = reconfig_pkg::MODE_CHANNEL,
    parameter int OC_CYCLES = reconfig_pkg::OC_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic word_wr_i,
    input wire logic [WORD_W-1:0] word_data_i,
    output logic word_ready_o,
    input wire logic idx_clr_i,
    output logic chan_wr_o,
    output logic [reconfig_pkg::IDX_W-1:0] chan_addr_o,
    output logic [WORD_W-1:0] chan_data_o,
    input wire logic chan_done_i,
    output logic [reconfig_pkg::IDX_W-1:0] idx_o,
    output logic idx_stb_o,
    output logic done_o,
    output logic busy_o
);
    localparam int IW = reconfig_pkg::IDX_W;
    localparam int OC_W = $clog2(OC_CYCLES + 1);

    // Power-up values: only oc_done survives the controller reset
    logic oc_done = 1'b0;
    logic [OC_W-1:0] oc_cnt = '0;
    logic oc_busy = 1'b0;

    reconfig_pkg::wr_state_t state;
    logic ctl_rst;
    logic [2:0] mode_reg;
    logic [2:0] mode_eff;
    logic [IW-1:0] last_addr;
    logic chan_mode;
    logic mode_err;
    logic run;
    logic clr_pend;
    logic buf_valid;
    logic buf_ready;
    logic [WORD_W-1:0] buf_data;
    logic pop;
    logic word_end;
    logic oc_last;
    logic bus_req;
    logic [31:0] rdata;

    // Without channel mode the reset port only clears wb_ack_o and wb_dat_o
    assign ctl_rst = (HAS_CHANNEL != 0) ? rst_i : 1'b0;

    assign mode_eff = (MULTI_MODE != 0) ? mode_reg : SINGLE_MODE;
    // Only two codes decode; PLL work belongs to another controller
    assign chan_mode = (HAS_CHANNEL != 0) &&
                       (mode_eff == reconfig_pkg::MODE_CHANNEL);
    assign mode_err = (mode_eff != reconfig_pkg::MODE_ANALOG) &&
                      (mode_eff != reconfig_pkg::MODE_CHANNEL);

    // Words wait in the buffer until cancellation is over
    assign run = chan_mode && oc_done;
    assign buf_ready = run && (state == reconfig_pkg::S_IDLE);
    assign pop = buf_valid && buf_ready;
    assign word_end = (state == reconfig_pkg::S_WRITE) && chan_done_i;
    assign oc_last = (oc_cnt == OC_W'(OC_CYCLES - 1));
    assign bus_req = wb_cyc_i && wb_stb_i;

    word_buffer #(
        .WIDTH(WORD_W),
        .DEPTH(reconfig_pkg::BUF_DEPTH)
    ) u_buf (
        .clk_i(clk_i),
        .rst_i(ctl_rst),
        .in_valid_i(word_wr_i && chan_mode),
        .in_data_i(word_data_i),
        .in_ready_o(word_ready_o),
        .out_valid_o(buf_valid),
        .out_data_o(buf_data),
        .out_ready_i(buf_ready)
    );

    // Offset cancellation: counter restarts while reset is held
    always_ff @(posedge clk_i) begin
        if (ctl_rst) begin
            oc_cnt <= '0;
        end else if (!oc_done) begin
            if (oc_last) begin
                oc_done <= 1'b1;
            end else begin
                oc_cnt <= oc_cnt + OC_W'(1);
            end
        end
    end
    // oc_done is never cleared by reset, so cancellation is not rerun.

    always_ff @(posedge clk_i) begin
        oc_busy <= !ctl_rst && !oc_done && !oc_last;
    end

    always_ff @(posedge clk_i) begin
        if (ctl_rst) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= (!oc_done && !oc_last) || pop ||
                      (state == reconfig_pkg::S_WRITE && !chan_done_i);
        end
    end

    // Channel writer
    always_ff @(posedge clk_i) begin
        if (ctl_rst) begin
            state <= reconfig_pkg::S_IDLE;
            chan_wr_o <= 1'b0;
            chan_addr_o <= reconfig_pkg::IDX_RST;
            chan_data_o <= '0;
        end else begin
            chan_wr_o <= 1'b0;
            unique case (state)
                reconfig_pkg::S_IDLE: begin
                    if (pop) begin
                        chan_wr_o <= 1'b1;
                        // A clear in this very cycle counts as well
                        chan_addr_o <= (clr_pend || (idx_clr_i && chan_mode))
                                       ? '0 : idx_o;
                        chan_data_o <= buf_data;
                        state <= reconfig_pkg::S_WRITE;
                    end
                end
                reconfig_pkg::S_WRITE: begin
                    if (chan_done_i) begin
                        state <= reconfig_pkg::S_IDLE;
                    end
                end
            endcase
        end
    end

    // Word index, strobe and completion flag
    always_ff @(posedge clk_i) begin
        if (ctl_rst) begin
            idx_o <= reconfig_pkg::IDX_RST;
            idx_stb_o <= 1'b0;
            done_o <= 1'b0;
            clr_pend <= 1'b0;
        end else begin
            idx_stb_o <= 1'b0;
            if (word_end) begin
                idx_stb_o <= 1'b1;
                clr_pend <= 1'b0;
                // Clear during a write: that word kept its old address
                if (clr_pend || (idx_clr_i && chan_mode)) begin
                    idx_o <= '0;
                end else if (chan_addr_o == last_addr) begin
                    idx_o <= '0;
                    done_o <= 1'b1;
                end else begin
                    // Step from the address used, so a word after a clear
                    // at zero is followed by one, never a second zero
                    idx_o <= chan_addr_o + IW'(1);
                end
            end else if (pop) begin
                // Address zero is taken now, so nothing stays pending
                clr_pend <= 1'b0;
                if (idx_o == '0 || clr_pend || (idx_clr_i && chan_mode)) begin
                    done_o <= 1'b0;
                end
            end else if (idx_clr_i && chan_mode) begin
                // Held until a word uses it, keeping idx steady
                clr_pend <= 1'b1;
            end
        end
    end

    // Wishbone slave: one-cycle ack, unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req && !wb_ack_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (ctl_rst) begin
            mode_reg <= reconfig_pkg::MODE_RST;
            last_addr <= reconfig_pkg::LAST_RST;
        end else if (bus_req && wb_we_i && wb_ack_o &&
                     wb_adr_i == reconfig_pkg::OFF_CTRL) begin
            if (wb_sel_i[0] && MULTI_MODE != 0) begin
                mode_reg <= wb_dat_i[reconfig_pkg::CTRL_MODE_LSB +: 3];
            end
            if (wb_sel_i[1]) begin
                last_addr <= wb_dat_i[reconfig_pkg::CTRL_LAST_LSB +: IW];
            end
        end
    end

    always_comb begin
        rdata = 32'h0000_0000;
        if (wb_adr_i == reconfig_pkg::OFF_CTRL) begin
            rdata[reconfig_pkg::CTRL_MODE_LSB +: 3] = mode_eff;
            rdata[reconfig_pkg::CTRL_LAST_LSB +: IW] = last_addr;
        end else if (wb_adr_i == reconfig_pkg::OFF_STATUS) begin
            rdata[reconfig_pkg::STAT_IDX_LSB +: IW] = idx_o;
            rdata[reconfig_pkg::STAT_DONE_BIT] = done_o;
            rdata[reconfig_pkg::STAT_BUSY_BIT] = busy_o;
            rdata[reconfig_pkg::STAT_OC_BIT] = oc_done;
            rdata[reconfig_pkg::STAT_MERR_BIT] = mode_err;
            rdata[reconfig_pkg::STAT_PEND_BIT] = clr_pend;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req && !wb_ack_o) begin
            wb_dat_o <= rdata;
        end
    end

    // Checks
    a_chan_mode_only: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(chan_wr_o) |-> $past(chan_mode))
        else $error("channel write outside channel mode");

    a_write_after_oc: assert property (@(posedge clk_i) disable iff (rst_i)
        chan_wr_o |-> oc_done && $past(oc_done))
        else $error("channel write before cancellation finished");

    a_idx_step: assert property (@(posedge clk_i) disable iff (rst_i)
        (word_end && !clr_pend && !idx_clr_i && chan_addr_o != last_addr)
        |=> idx_stb_o && idx_o == $past(chan_addr_o) + IW'(1))
        else $error("index did not step by one");

    a_idx_wrap_done: assert property (@(posedge clk_i) disable iff (rst_i)
        (word_end && !clr_pend && !idx_clr_i && chan_addr_o == last_addr)
        |=> idx_o == '0 && done_o)
        else $error("index did not wrap with completion");

    a_strobe_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        idx_stb_o |-> $past(word_end))
        else $error("index strobe without a finished word");

    a_idx_steady: assert property (@(posedge clk_i) disable iff (rst_i)
        !idx_stb_o && !$past(rst_i) |-> $stable(idx_o))
        else $error("index moved without its strobe");

    a_done_drop: assert property (@(posedge clk_i) disable iff (rst_i)
        (pop && idx_o == '0) |=> !done_o)
        else $error("completion flag kept at new sequence");

    a_clear_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (pop && (clr_pend || (idx_clr_i && chan_mode)))
        |=> chan_wr_o && chan_addr_o == '0)
        else $error("write after clear not at address zero");

    // Pulses, holds and reset values
    a_done_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (done_o && !pop) |=> done_o)
        else $error("completion flag dropped without a new sequence");

    a_stb_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        idx_stb_o |=> !idx_stb_o)
        else $error("index strobe longer than one cycle");

    a_wr_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        chan_wr_o |=> !chan_wr_o && state == reconfig_pkg::S_WRITE)
        else $error("channel write longer than one cycle");

    a_busy_write: assert property (@(posedge clk_i) disable iff (rst_i)
        chan_wr_o |-> busy_o)
        else $error("busy low while a word is written");

    a_rst_values: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rst_i) |-> idx_o == '0 && !done_o && !chan_wr_o && !idx_stb_o)
        else $error("state not cleared by reset");

    // No disable here: the count must stay at zero while reset is held
    a_oc_wait_rst: assert property (@(posedge clk_i)
        (ctl_rst && !oc_done) |=> oc_cnt == '0)
        else $error("cancellation counted during reset");

    a_clr_steady: assert property (@(posedge clk_i) disable iff (rst_i)
        (idx_clr_i && chan_mode && !word_end) |=> $stable(idx_o))
        else $error("index moved on a deferred clear");

    a_oc_busy: assert property (@(posedge clk_i) disable iff (rst_i)
        (!oc_done && !oc_last) |=> oc_busy && busy_o)
        else $error("busy low during cancellation");

    a_oc_once: assert property (@(posedge clk_i) disable iff (rst_i)
        oc_done |=> oc_done && !oc_busy)
        else $error("cancellation ran again");

    c_wrap: cover property (@(posedge clk_i) disable iff (rst_i)
        $rose(done_o));
    c_stall: cover property (@(posedge clk_i) disable iff (rst_i)
        word_wr_i && !word_ready_o);
    c_clear: cover property (@(posedge clk_i) disable iff (rst_i)
        idx_clr_i && state == reconfig_pkg::S_WRITE);
    c_oc_end: cover property (@(posedge clk_i) disable iff (rst_i)
        $rose(oc_done));
    c_clear_idle: cover property (@(posedge clk_i) disable iff (rst_i)
        idx_clr_i && state == reconfig_pkg::S_IDLE);

endmodule : channel_reconfig_word_sequencer

// file: bench/chan_model.sv
// Channel side model that acknowledges each written word after a set lag
`timescale 1ns/100ps
module chan_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic chan_wr_i,
    input wire logic [7:0] lag_i,
    output logic chan_done_o
);
    logic [7:0] cnt = 8'h00;
    logic run = 1'b0;
    initial chan_done_o = 1'b0;
    // A reset drops the word in flight, as the real channel would
    always @(posedge clk_i) begin
        chan_done_o <= 1'b0;
        if (rst_i) begin
            run <= 1'b0;
        end else if (chan_wr_i) begin
            run <= 1'b1;
            cnt <= lag_i;
        end else if (run && cnt == 8'h00) begin
            run <= 1'b0;
            chan_done_o <= 1'b1;
        end else if (run) begin
            cnt <= cnt - 8'h01;
        end
    end
endmodule : chan_model

// file: bench/channel_reconfig_word_sequencer_tb.sv
// Self-checking bench for the channel reconfiguration word sequencer
`timescale 1ns/100ps
module channel_reconfig_word_sequencer_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, word_wr_i = 1'b0, word_ready_o, idx_clr_i = 1'b0;
    logic [15:0] word_data_i = 16'h0, chan_data_o;
    logic chan_wr_o, chan_done_i, idx_stb_o, done_o, busy_o, rst_q, stalled;
    logic [5:0] chan_addr_o, idx_o, idx_prev;
    logic [7:0] lag = 8'h03;
    logic [21:0] wq[$];
    logic [5:0] iq[$];
    logic [31:0] q;
    int err_total = 0;
    int checks = 0;

    always #2 clk_i = ~clk_i;

    channel_reconfig_word_sequencer #(.OC_CYCLES(4)) i_channel_reconfig_word_sequencer (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .word_wr_i(word_wr_i), .word_data_i(word_data_i),
        .word_ready_o(word_ready_o), .idx_clr_i(idx_clr_i),
        .chan_wr_o(chan_wr_o), .chan_addr_o(chan_addr_o),
        .chan_data_o(chan_data_o), .chan_done_i(chan_done_i), .idx_o(idx_o),
        .idx_stb_o(idx_stb_o), .done_o(done_o), .busy_o(busy_o));

    chan_model i_chan_model (.clk_i(clk_i), .rst_i(rst_i),
        .chan_wr_i(chan_wr_o), .lag_i(lag), .chan_done_o(chan_done_i));

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    // Monitor of channel writes, index strobes and index stability
    always @(posedge clk_i) begin
        rst_q <= rst_i;
        idx_prev <= idx_o;
        if (chan_wr_o === 1'b1) wq.push_back({chan_addr_o, chan_data_o});
        if (idx_stb_o === 1'b1) iq.push_back(idx_o);
        else if (!rst_i && !rst_q) chk("idx_hold", 32'(idx_prev), 32'(idx_o));
    end

    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) chk("wb_ack", 32'h1, 32'h0);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    // Strobe stays high across back-to-back words; caller lowers it
    task automatic push(input logic [15:0] w);
        int n;
        n = 0;
        word_wr_i <= 1'b1;
        word_data_i <= w;
        do begin
            @(posedge clk_i);
            n++;
            if (word_ready_o === 1'b0) stalled = 1'b1;
        end while (word_ready_o !== 1'b1 && n < 200);
        if (n >= 200) chk("push_ready", 32'h1, 32'h0);
    endtask : push

    task automatic expect_word(input logic [5:0] a, input logic [15:0] d);
        int n;
        n = 0;
        while (wq.size() == 0 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        chk("chan_word", 32'({a, d}), (n < 300) ? 32'(wq.pop_front()) : 32'h0);
    endtask : expect_word

    task automatic expect_idx(input logic [5:0] i);
        int n;
        n = 0;
        while (iq.size() == 0 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        chk("idx_stb", 32'(i), (n < 300) ? 32'(iq.pop_front()) : 32'hFF);
    endtask : expect_idx

    task automatic t_power_up();
        int n;
        n = 0;
        while (busy_o !== 1'b1 && n < 4) begin
            @(posedge clk_i);
            n++;
        end
        chk("busy_rise", 32'h1, 32'(busy_o));
        n = 0;
        while (busy_o !== 1'b0 && n < 12) begin
            @(posedge clk_i);
            n++;
        end
        chk("busy_fall", 32'h0, 32'(busy_o));
    endtask : t_power_up

    task automatic t_regs_and_analog();
        wb(8'h00, 1'b0, 32'h0);
        chk("ctrl_reset", 32'h3F00, q);
        push(16'hAAAA);
        word_wr_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        chk("analog_drop", 32'h0, 32'(wq.size()));
        wb(8'h00, 1'b1, 32'h0201);
        wb(8'h00, 1'b0, 32'h0);
        chk("ctrl_rw", 32'h0201, q);
        wb(8'h10, 1'b0, 32'h0);
        chk("unmapped", 32'h0, q);
    endtask : t_regs_and_analog

    task automatic t_sequence();
        push(16'h1234);
        push(16'h5678);
        push(16'h9ABC);
        word_wr_i <= 1'b0;
        expect_word(6'h00, 16'h1234);
        expect_word(6'h01, 16'h5678);
        expect_word(6'h02, 16'h9ABC);
        expect_idx(6'h01);
        expect_idx(6'h02);
        expect_idx(6'h00);
        @(posedge clk_i);
        chk("done_set", 32'h1, 32'(done_o));
        wb(8'h04, 1'b0, 32'h0);
        chk("status", 32'h100, q & 32'h13F);
    endtask : t_sequence

    task automatic t_stall_restart();
        lag <= 8'h1E;
        stalled = 1'b0;
        push(16'h0D0D);
        push(16'h0E0E);
        push(16'h0F0F);
        push(16'h0101);
        word_wr_i <= 1'b0;
        chk("buf_stall", 32'h1, 32'(stalled));
        expect_word(6'h00, 16'h0D0D);
        expect_word(6'h01, 16'h0E0E);
        expect_word(6'h02, 16'h0F0F);
        expect_word(6'h00, 16'h0101);
        expect_idx(6'h01);
        expect_idx(6'h02);
        expect_idx(6'h00);
        expect_idx(6'h01);
        chk("done_clear", 32'h0, 32'(done_o));
        chk("idx_after", 32'h1, 32'(idx_o));
    endtask : t_stall_restart

    task automatic t_clear();
        lag <= 8'h03;
        idx_clr_i <= 1'b1;
        @(posedge clk_i);
        idx_clr_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        wb(8'h04, 1'b0, 32'h0);
        chk("clr_pend", 32'h1001, q & 32'h113F);
        push(16'h4242);
        word_wr_i <= 1'b0;
        expect_word(6'h00, 16'h4242);
        expect_idx(6'h01);
        chk("clr_strobes", 32'h0, 32'(iq.size()));
    endtask : t_clear

    task automatic t_mid_reset();
        int seen;
        seen = 0;
        lag <= 8'h28;
        push(16'h7777);
        word_wr_i <= 1'b0;
        expect_word(6'h01, 16'h7777);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("rst_idx", 32'h0, 32'(idx_o));
        chk("rst_done", 32'h0, 32'(done_o));
        repeat (8) begin
            @(posedge clk_i);
            if (busy_o !== 1'b0) seen++;
        end
        chk("no_recancel", 32'h0, 32'(seen));
        wb(8'h00, 1'b0, 32'h0);
        chk("rst_ctrl", 32'h3F00, q);
    endtask : t_mid_reset

    initial begin
        #(4 * 20000);
        err_total++;
        give_verdict();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_power_up();
        t_regs_and_analog();
        t_sequence();
        t_stall_restart();
        t_clear();
        t_mid_reset();
        give_verdict();
    end
endmodule : channel_reconfig_word_sequencer_tb
